/* hw/error_scope_pkg.sv */
package error_scope_pkg;

  // --------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------
  localparam int GROUPS = 6;
  localparam int CNT_W = 12;
  localparam int LINE_W = 26;
  localparam int AV_ADDR_W = 6;
  localparam int AV_DATA_W = 32;
  localparam int AV_BE_W = AV_DATA_W / 8;
  localparam int SCRUB_W = 5;
  localparam int TIMER_W = 32;

  // --------------------------------------------------------------------
  // Enumerations
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_SYS_FATAL  = 2'b00,
    KIND_PROC_FATAL = 2'b01,
    KIND_DEFERRED   = 2'b10,
    KIND_CORRECTED  = 2'b11
  } err_kind_e;

  typedef enum logic [2:0] {
    GRP_INSTR  = 3'b000,
    GRP_DATA   = 3'b001,
    GRP_CACHE  = 3'b010,
    GRP_MEMORY = 3'b011,
    GRP_LINK   = 3'b100,
    GRP_FIFTH  = 3'b101
  } group_e;

  // Only the memory and link groups may raise a threshold event
  localparam logic [GROUPS-1:0] EVENT_CAPABLE = 6'h18;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    err_kind_e kind;
    logic poison;
    logic restart_ok;
    logic ip_related;
    group_e group;
    logic scrub;
    logic dual;
    logic [LINE_W-1:0] line;
  } err_report_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [AV_ADDR_W-1:0] address;
    logic [AV_DATA_W-1:0] writedata;
    logic [AV_BE_W-1:0] byteenable;
  } av_req_s;

  typedef struct packed {
    logic [AV_DATA_W-1:0] readdata;
    logic waitrequest;
  } av_rsp_s;

  typedef struct packed {
    logic shutdown;
    logic exception_in_progress;
    group_e group;
    logic scrub;
    logic error_pointer_valid;
    logic restart_pointer_valid;
    logic overflow;
    logic poison;
    logic deferred;
    logic context_corrupt_flag;
    logic uc;
    logic valid;
  } mca_status_s;

  localparam int ST_W = $bits(mca_status_s);

  // --------------------------------------------------------------------
  // Register map (byte addresses, word index = address[5:2])
  // --------------------------------------------------------------------
  localparam logic [AV_ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [AV_ADDR_W-1:0] OFS_STATUS = 6'h04;
  localparam logic [AV_ADDR_W-1:0] OFS_EVENT = 6'h08;
  localparam logic [AV_ADDR_W-1:0] OFS_SCRUB_LINE = 6'h0C;
  localparam logic [AV_ADDR_W-3:0] IDX_COUNT_BASE = 4'h4;
  localparam logic [AV_ADDR_W-3:0] IDX_THRESH_BASE = 4'hA;

  localparam int CTRL_MEM_EV_BIT = 8;
  localparam int CTRL_LINK_EV_BIT = 9;
  localparam int EVT_REACHED_LSB = 8;

  // W1C bits of the status word: valid, overflow, exception_in_progress
  localparam logic [ST_W-1:0] STATUS_W1C = 14'h1021;
  localparam logic [AV_DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

  // --------------------------------------------------------------------
  // Scrub interval encoding
  // --------------------------------------------------------------------
  localparam logic [SCRUB_W-1:0] SCRUB_OFF = 5'h00;
  localparam logic [SCRUB_W-1:0] SCRUB_SHORTEST = 5'h0A;
  localparam logic [SCRUB_W-1:0] SCRUB_LONGEST = 5'h12;
  localparam real SCRUB_SHORTEST_US = 20.5;
  localparam real CLK_PERIOD_NS = 5.0;
  localparam int unsigned SCRUB_SHORTEST_CYCLES =
    int'($floor(SCRUB_SHORTEST_US * 1000.0 / CLK_PERIOD_NS));

endpackage : error_scope_pkg

/* hw/error_scope_threshold_scrub.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Context-corrupting error sets context-corrupt and uncorrected, raises fatal machine check.
// - Process-confined uncorrected error: context-corrupt clear, uncorrected set, machine check.
// - Consumed poisoned data also sets the poison indication in the status.
// - Latent unconsumed error logs deferred only, no exception until consumed.
// - Deferred errors are logged from demand accesses and from scrub accesses.
// - Corrected error clears all severity flags, no exception, logged and counted.
// - One counter per threshold group, optional event at programmed threshold.
// - Group counter increments on corrected, deferred and uncorrected errors.
// - Only a count is kept; software derives any error rate.
// - Instruction, data, cache and fifth groups count but never raise events.
// - Memory group counts and may raise an event at threshold.
// - Link group counts in its own counter, event optional.
// - Two simultaneous errors may count once; overflow records the second.
// - Scrubber periodically reads cacheline data with tags; findings logged normally.
// - Correctable error found by scrub is corrected in place.
// - Setting 0Ah selects 20.5 us, the shortest tabulated interval.
// - Machine check while exception-in-progress set puts the core in shutdown.
module error_scope_threshold_scrub #(
  parameter int unsigned SCRUB_MIN_CYCLES = error_scope_pkg::SCRUB_SHORTEST_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire error_scope_pkg::av_req_s av_req,
  output var error_scope_pkg::av_rsp_s av_rsp,
  input wire error_scope_pkg::err_report_s err,
  output logic mce_q,
  output logic mce_fatal_q,
  output logic shutdown_q,
  output logic thr_event_q,
  output logic scrub_req_q,
  output logic [error_scope_pkg::LINE_W-1:0] scrub_line_q,
  output logic scrub_fix_q,
  output logic [error_scope_pkg::LINE_W-1:0] scrub_fix_line_q
);
  import error_scope_pkg::*;

  // --------------------------------------------------------------------
  // Avalon-MM slave
  // --------------------------------------------------------------------
  logic wait_q;
  logic [AV_DATA_W-1:0] rdata_q;
  logic [AV_DATA_W-1:0] rd_mux;
  logic [AV_DATA_W-1:0] wmask;
  logic [AV_DATA_W-1:0] wbits;
  logic wr_en;
  logic [AV_ADDR_W-3:0] widx;

  // Byte lanes expanded to a bit mask
  always_comb begin
    for (int b = 0; b < AV_BE_W; b++) begin
      wmask[b*8 +: 8] = {8{av_req.byteenable[b]}};
    end
  end

  assign wbits = av_req.writedata & wmask;
  assign wr_en = av_req.write & ~wait_q;
  assign widx = av_req.address[AV_ADDR_W-1:2];

  // One wait cycle per access; read data captured while waiting
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else if (ce) begin
      if ((av_req.read | av_req.write) & wait_q) begin
        wait_q <= 1'b0;
        rdata_q <= av_req.read ? rd_mux : '0;
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  assign av_rsp.readdata = rdata_q;
  assign av_rsp.waitrequest = wait_q;

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  logic [AV_DATA_W-1:0] ctrl_q;
  logic [SCRUB_W-1:0] scrub_set;
  logic [GROUPS-1:0] ev_en;

  // Masked write keeps untouched lanes
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ce && wr_en && av_req.address == OFS_CTRL) begin
      ctrl_q <= (ctrl_q & ~wmask) | wbits;
    end
  end

  assign scrub_set = ctrl_q[SCRUB_W-1:0];

  // Enables exist only for event-capable groups
  always_comb begin
    ev_en = '0;
    ev_en[GRP_MEMORY] = ctrl_q[CTRL_MEM_EV_BIT];
    ev_en[GRP_LINK] = ctrl_q[CTRL_LINK_EV_BIT];
    ev_en = ev_en & EVENT_CAPABLE;
  end

  // --------------------------------------------------------------------
  // Severity classification and logging
  // --------------------------------------------------------------------
  mca_status_s st_q;
  logic mce_now;
  logic [ST_W-1:0] st_clr;

  assign mce_now = err.valid &
    (err.kind == KIND_SYS_FATAL || err.kind == KIND_PROC_FATAL);
  assign st_clr = (wr_en && av_req.address == OFS_STATUS) ?
    (wbits[ST_W-1:0] & STATUS_W1C) : '0;

  // Software clears first; a new error in the same cycle overrides it
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= mca_status_s'(st_q & ~st_clr);
      if (err.valid) begin
        st_q.valid <= 1'b1;
        st_q.group <= err.group;
        st_q.scrub <= err.scrub;
        st_q.overflow <= st_q.overflow | (st_q.valid & ~st_clr[0]) | err.dual;
        unique case (err.kind)
          KIND_SYS_FATAL: begin
            st_q.context_corrupt_flag <= 1'b1;
            st_q.uc <= 1'b1;
            st_q.deferred <= 1'b0;
            st_q.poison <= err.poison;
            st_q.restart_pointer_valid <= 1'b0;
            st_q.error_pointer_valid <= err.ip_related;
          end
          KIND_PROC_FATAL: begin
            st_q.context_corrupt_flag <= 1'b0;
            st_q.uc <= 1'b1;
            st_q.deferred <= 1'b0;
            st_q.poison <= err.poison;
            st_q.restart_pointer_valid <= err.restart_ok;
            st_q.error_pointer_valid <= err.ip_related;
          end
          KIND_DEFERRED: begin
            st_q.context_corrupt_flag <= 1'b0;
            st_q.uc <= 1'b0;
            st_q.deferred <= 1'b1;
            st_q.poison <= 1'b0;
          end
          KIND_CORRECTED: begin
            st_q.context_corrupt_flag <= 1'b0;
            st_q.uc <= 1'b0;
            st_q.deferred <= 1'b0;
            st_q.poison <= 1'b0;
          end
        endcase
      end
      if (mce_now) begin
        st_q.exception_in_progress <= 1'b1;
        st_q.shutdown <= st_q.shutdown | (st_q.exception_in_progress & ~st_clr[ST_W-2]);
      end
    end
  end

  // Exception pulses only for the two uncorrected kinds
  always_ff @(posedge clk) begin
    if (srst) begin
      mce_q <= 1'b0;
      mce_fatal_q <= 1'b0;
      shutdown_q <= 1'b0;
    end else if (ce) begin
      mce_q <= mce_now;
      mce_fatal_q <= mce_now & (err.kind == KIND_SYS_FATAL);
      shutdown_q <= shutdown_q | (mce_now & st_q.exception_in_progress & ~st_clr[ST_W-2]);
    end
  end

  // --------------------------------------------------------------------
  // Threshold groups
  // --------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q [GROUPS];
  logic [CNT_W-1:0] thr_q [GROUPS];
  logic [GROUPS-1:0] fire;
  logic [GROUPS-1:0] reached;
  logic [GROUPS-1:0] evt_q;
  logic [GROUPS-1:0] evt_clr;

  generate
    for (genvar g = 0; g < GROUPS; g++) begin : grp
      logic hit;
      logic [CNT_W-1:0] cnt_next;
      logic [AV_ADDR_W-3:0] cidx;
      logic [AV_ADDR_W-3:0] tidx;

      assign cidx = IDX_COUNT_BASE + (AV_ADDR_W-2)'(g);
      assign tidx = IDX_THRESH_BASE + (AV_ADDR_W-2)'(g);
      // Dual errors still count once
      assign hit = err.valid && err.group == group_e'(g);
      assign cnt_next = (&cnt_q[g]) ? cnt_q[g] : cnt_q[g] + 1'b1;
      assign fire[g] = hit && cnt_next == thr_q[g] && cnt_q[g] != thr_q[g] &&
        ev_en[g];
      assign reached[g] = cnt_q[g] >= thr_q[g];

      // Counting beats a software preload in the same cycle
      always_ff @(posedge clk) begin
        if (srst) begin
          cnt_q[g] <= '0;
        end else if (ce) begin
          if (hit) begin
            cnt_q[g] <= cnt_next;
          end else if (wr_en && widx == cidx) begin
            cnt_q[g] <= wbits[CNT_W-1:0];
          end
        end
      end

      // Threshold value is software owned
      always_ff @(posedge clk) begin
        if (srst) begin
          thr_q[g] <= '0;
        end else if (ce && wr_en && widx == tidx) begin
          thr_q[g] <= (thr_q[g] & ~wmask[CNT_W-1:0]) | wbits[CNT_W-1:0];
        end
      end
    end
  endgenerate

  assign evt_clr = (wr_en && av_req.address == OFS_EVENT) ? wbits[GROUPS-1:0] : '0;

  // Sticky event bits, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      evt_q <= '0;
      thr_event_q <= 1'b0;
    end else if (ce) begin
      evt_q <= (evt_q & ~evt_clr) | fire;
      thr_event_q <= |fire;
    end
  end

  // --------------------------------------------------------------------
  // Scrubber
  // --------------------------------------------------------------------
  logic [TIMER_W-1:0] timer_q;
  logic [TIMER_W-1:0] interval;
  logic [SCRUB_W-1:0] eff_set;

  // Interval doubles per step above the shortest setting
  always_comb begin
    eff_set = (scrub_set > SCRUB_LONGEST) ? SCRUB_LONGEST : scrub_set;
    if (eff_set >= SCRUB_SHORTEST) begin
      interval = TIMER_W'(SCRUB_MIN_CYCLES) << (eff_set - SCRUB_SHORTEST);
    end else begin
      interval = TIMER_W'(SCRUB_MIN_CYCLES) >> (SCRUB_SHORTEST - eff_set);
    end
    if (interval == '0) begin
      interval = TIMER_W'(1);
    end
  end

  // Issues one cacheline-with-tag read per interval
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_q <= '0;
      scrub_req_q <= 1'b0;
      scrub_line_q <= '0;
    end else if (ce) begin
      scrub_req_q <= 1'b0;
      if (scrub_set == SCRUB_OFF) begin
        timer_q <= '0;
      end else if (timer_q >= interval - 1'b1) begin
        timer_q <= '0;
        scrub_req_q <= 1'b1;
        scrub_line_q <= scrub_line_q + 1'b1;
      end else begin
        timer_q <= timer_q + 1'b1;
      end
    end
  end

  // Write back corrected data found by a scrub read
  always_ff @(posedge clk) begin
    if (srst) begin
      scrub_fix_q <= 1'b0;
      scrub_fix_line_q <= '0;
    end else if (ce) begin
      scrub_fix_q <= err.valid & err.scrub & (err.kind == KIND_CORRECTED);
      if (err.valid & err.scrub) begin
        scrub_fix_line_q <= err.line;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  always_comb begin
    logic [AV_ADDR_W-3:0] ridx;
    ridx = av_req.address[AV_ADDR_W-1:2];
    rd_mux = '0;
    if (av_req.address == OFS_CTRL) begin
      rd_mux = ctrl_q;
    end else if (av_req.address == OFS_STATUS) begin
      rd_mux[ST_W-1:0] = st_q;
    end else if (av_req.address == OFS_EVENT) begin
      rd_mux[GROUPS-1:0] = evt_q;
      rd_mux[EVT_REACHED_LSB +: GROUPS] = reached;
    end else if (av_req.address == OFS_SCRUB_LINE) begin
      rd_mux[LINE_W-1:0] = scrub_line_q;
    end else begin
      for (int g = 0; g < GROUPS; g++) begin
        if (ridx == IDX_COUNT_BASE + (AV_ADDR_W-2)'(g)) begin
          rd_mux[CNT_W-1:0] = cnt_q[g];
        end
        if (ridx == IDX_THRESH_BASE + (AV_ADDR_W-2)'(g)) begin
          rd_mux[CNT_W-1:0] = thr_q[g];
        end
      end
    end
  end

endmodule : error_scope_threshold_scrub
`default_nettype wire

/* tb/error_scope_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module error_scope_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire error_scope_pkg::av_req_s av_req,
  input wire error_scope_pkg::av_rsp_s av_rsp,
  input wire error_scope_pkg::err_report_s err,
  input wire logic mce_q,
  input wire logic mce_fatal_q,
  input wire logic shutdown_q,
  input wire logic thr_event_q,
  input wire logic scrub_req_q,
  input wire logic [error_scope_pkg::LINE_W-1:0] scrub_line_q,
  input wire logic scrub_fix_q,
  input wire logic [error_scope_pkg::LINE_W-1:0] scrub_fix_line_q
);
  import error_scope_pkg::*;
  logic hit;
  logic mce_src;
  logic ev_src;
  // Causes seen at the error port; only two groups may fire events
  assign hit = err.valid && ce;
  assign mce_src = hit && !err.kind[1];
  assign ev_src = hit && (err.group == GRP_MEMORY || err.group == GRP_LINK);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----
  // Severity and threshold events
  // ----
  chk_fatal_mce:
    assert property (hit && err.kind == KIND_SYS_FATAL |=> mce_q && mce_fatal_q)
    else $error("fatal error gave no fatal machine check");
  chk_proc_mce:
    assert property (hit && err.kind == KIND_PROC_FATAL |=> mce_q && !mce_fatal_q)
    else $error("process error gave wrong machine check");
  chk_defer_quiet:
    assert property (hit && err.kind == KIND_DEFERRED |=> !mce_q)
    else $error("deferred error raised a machine check");
  chk_corr_quiet:
    assert property (hit && err.kind == KIND_CORRECTED |=> !mce_q)
    else $error("corrected error raised a machine check");
  chk_mce_cause:
    assert property (mce_q && $past(ce) |-> $past(mce_src))
    else $error("machine check without an uncorrected error");
  chk_shut_sticky:
    assert property (shutdown_q && !srst |=> shutdown_q)
    else $error("shutdown left without reset");
  chk_event_group:
    assert property (thr_event_q && $past(ce) |-> $past(ev_src))
    else $error("threshold event from a polled group");
  // ----
  // Scrubber and bus
  // ----
  chk_fix_scrub:
    assert property (hit && err.scrub && err.kind == KIND_CORRECTED
      |=> scrub_fix_q && scrub_fix_line_q == $past(err.line))
    else $error("scrub correction missing");
  chk_scrub_step:
    assert property (scrub_req_q && $past(ce)
      |-> scrub_line_q == $past(scrub_line_q) + 1'b1)
    else $error("scrub line did not advance");
  chk_wait_pulse:
    assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
    else $error("waitrequest low too long");
  chk_wait_answer:
    assert property (ce && (av_req.read || av_req.write) && av_rsp.waitrequest
      |=> !av_rsp.waitrequest)
    else $error("bus access not answered");
  // Main scenarios reached
  cov_fatal: cover property (mce_fatal_q);
  cov_event: cover property (thr_event_q);
  cov_scrub: cover property (scrub_req_q);
  cov_shut: cover property (shutdown_q);
endmodule : error_scope_checker

bind error_scope_threshold_scrub error_scope_checker i_error_scope_checker (
  .clk(clk), .srst(srst), .ce(ce), .av_req(av_req), .av_rsp(av_rsp), .err(err),
  .mce_q(mce_q), .mce_fatal_q(mce_fatal_q), .shutdown_q(shutdown_q),
  .thr_event_q(thr_event_q), .scrub_req_q(scrub_req_q), .scrub_line_q(scrub_line_q),
  .scrub_fix_q(scrub_fix_q), .scrub_fix_line_q(scrub_fix_line_q));
`default_nettype wire

/* tb/test_error_scope_threshold_scrub.sv */
`timescale 1ns/1ps
`default_nettype none
module test_error_scope_threshold_scrub;
  import error_scope_pkg::*;
  localparam int MINC = 4;
  localparam logic [4:0] SET [4] = '{5'h0A, 5'h0B, 5'h0D, 5'h12};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  av_req_s req = '0;
  av_rsp_s rsp;
  err_report_s e = '0;
  logic mce, fat, shut, thr_ev, scr, fix;
  logic [LINE_W-1:0] line, fix_line;
  int num_errors = 0;
  int n_checks = 0;
  integer seed = 32'hD91E4A10;
  int cnt [GROUPS];
  int thr [GROUPS];
  logic mem_en, link_en;
  mca_status_s ms;
  logic [EVT_REACHED_LSB+GROUPS-1:0] evx;
  logic [31:0] rd;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  error_scope_threshold_scrub #(.SCRUB_MIN_CYCLES(MINC)) i_error_scope_threshold_scrub (
    .clk(clk), .srst(srst), .ce(ce), .av_req(req), .av_rsp(rsp), .err(e), .mce_q(mce),
    .mce_fatal_q(fat), .shutdown_q(shut), .thr_event_q(thr_ev), .scrub_req_q(scr),
    .scrub_line_q(line), .scrub_fix_q(fix), .scrub_fix_line_q(fix_line));

  // ----
  // Reporting
  // ----
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic ck(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : ck

  // Model back to its reset state
  task automatic clear_model();
    ms = '0;
    evx = '0;
    mem_en = 1'b0;
    link_en = 1'b0;
    foreach (cnt[i]) begin
      cnt[i] = 0;
      thr[i] = 0;
    end
  endtask : clear_model

  // ----
  // Drivers
  // ----
  // One access; held until waitrequest is sampled low, model follows writes
  task automatic bus(input logic we, input logic [AV_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{read: !we, write: we, address: a, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
    if (we && a == OFS_CTRL) begin
      mem_en = d[CTRL_MEM_EV_BIT];
      link_en = d[CTRL_LINK_EV_BIT];
    end
    if (we && a == OFS_STATUS) ms = ms & ~(d[ST_W-1:0] & STATUS_W1C);
    if (we && a[5:2] >= 4 && a[5:2] <= 9) cnt[a[5:2] - 4] = d[11:0];
    if (we && a[5:2] >= 10) thr[a[5:2] - 10] = d[11:0];
    @(posedge clk);
  endtask : bus

  task automatic rdck(input string nm, input logic [AV_ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    ck(nm, rd, exp);
  endtask : rdck

  // One error report; counters saturate, so a full counter gives no new event
  task automatic send(input err_kind_e k, input int g, input logic sc, input logic du);
    int old;
    logic p, r, ip, ev;
    p = 1'($random(seed));
    r = 1'($random(seed));
    ip = 1'($random(seed));
    e <= '{valid: 1'b1, kind: k, poison: p, restart_ok: r, ip_related: ip,
      group: group_e'(g), scrub: sc, dual: du, line: LINE_W'($random(seed))};
    old = cnt[g];
    if (cnt[g] < 4095) cnt[g]++;
    ev = cnt[g] == thr[g] && old != thr[g] && ((g == 3 && mem_en) || (g == 4 && link_en));
    if (k < 2 && ms.exception_in_progress) ms.shutdown = 1'b1;
    ms.overflow = ms.overflow | ms.valid | du;
    ms.valid = 1'b1;
    ms.uc = k < 2;
    ms.context_corrupt_flag = k == KIND_SYS_FATAL;
    ms.deferred = k == KIND_DEFERRED;
    ms.poison = k < 2 && p;
    if (k < 2) begin
      ms.restart_pointer_valid = k == KIND_PROC_FATAL && r;
      ms.error_pointer_valid = ip;
      ms.exception_in_progress = 1'b1;
    end
    ms.scrub = sc;
    ms.group = group_e'(g);
    if (ev) evx[g] = 1'b1;
    @(posedge clk);
    e.valid <= 1'b0;
    @(posedge clk);
    ck("mce", mce, k < 2);
    ck("fatal", fat, k == KIND_SYS_FATAL);
    ck("event", thr_ev, ev);
    ck("shutdown", shut, ms.shutdown);
    ck("scrub fix", fix, sc && k == KIND_CORRECTED);
    if (sc) ck("fix line", fix_line, e.line);
  endtask : send

  // Next scrub pulse, cycles counted; a missing pulse ends the run
  task automatic pulse(output int w);
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (scr !== 1'b1 && w < 5000);
    if (w >= 5000) begin
      num_errors++;
      stop_test();
    end
  endtask : pulse

  // ----
  // Sequence
  // ----
  initial begin
    int w;
    logic [LINE_W-1:0] ln;
    clear_model();
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int g = 0; g < GROUPS; g++) rdck("count", 6'(16 + 4 * g), 0);
    rdck("status", OFS_STATUS, 0);
    $display("test reset done");
    // Every kind, demand and scrub origin, status cleared between
    for (int i = 0; i < 24; i++) begin
      send(err_kind_e'(i % 4), i % 6, i[2], 1'b0);
      rdck("status", OFS_STATUS, 32'(ms));
      bus(1'b1, OFS_STATUS, 32'(STATUS_W1C));
    end
    for (int g = 0; g < GROUPS; g++) rdck("count", 6'(16 + 4 * g), cnt[g]);
    send(KIND_CORRECTED, 2, 1'b0, 1'b1);
    rdck("status", OFS_STATUS, 32'(ms));
    rdck("count", 6'h18, cnt[2]);
    $display("test classes done");
    // Enabled memory group fires once per threshold crossing, link only when enabled, polled group never
    bus(1'b1, 6'h34, 32'(cnt[3] + 2));
    bus(1'b1, OFS_CTRL, 32'h100);
    repeat (3) send(KIND_CORRECTED, 3, 1'b0, 1'b0);
    bus(1'b1, 6'h38, 32'(cnt[4] + 1));
    send(KIND_DEFERRED, 4, 1'b0, 1'b0);
    bus(1'b1, 6'h38, 32'(cnt[4] + 1));
    bus(1'b1, OFS_CTRL, 32'h300);
    send(KIND_DEFERRED, 4, 1'b0, 1'b0);
    bus(1'b1, 6'h28, 32'(cnt[0] + 1));
    send(KIND_CORRECTED, 0, 1'b0, 1'b0);
    bus(1'b1, 6'h1C, 32'hFFE);
    bus(1'b1, 6'h34, 32'hFFF);
    repeat (2) send(KIND_CORRECTED, 3, 1'b0, 1'b0);
    rdck("count", 6'h1C, 32'hFFF);
    rdck("thresh", 6'h34, 32'hFFF);
    // Sticky fired bits plus reached bits, then fired bits cleared by software
    foreach (cnt[g]) evx[EVT_REACHED_LSB + g] = cnt[g] >= thr[g];
    rdck("events", OFS_EVENT, 32'(evx));
    bus(1'b1, OFS_EVENT, 32'h3F);
    evx[GROUPS-1:0] = '0;
    rdck("events", OFS_EVENT, 32'(evx));
    $display("test thresholds done");
    // Interval doubles per step; first two intervals skipped as the timer may restart
    foreach (SET[i]) begin
      bus(1'b1, OFS_CTRL, 32'(SET[i]));
      pulse(w);
      pulse(w);
      ln = line;
      pulse(w);
      ck("interval", w, MINC << (SET[i] - 5'h0A));
      ck("line", line, ln + 1'b1);
    end
    bus(1'b1, OFS_CTRL, 32'h0);
    w = 0;
    repeat (4) @(posedge clk);
    repeat (2000) begin
      @(posedge clk);
      if (scr !== 1'b0) w++;
    end
    ck("scrub off", w, 0);
    rdck("scrub line", OFS_SCRUB_LINE, 32'(line));
    $display("test scrub done");
    // Second machine check while the first is still in progress
    send(KIND_PROC_FATAL, 1, 1'b0, 1'b0);
    send(KIND_SYS_FATAL, 1, 1'b0, 1'b0);
    rdck("status", OFS_STATUS, 32'(ms));
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    clear_model();
    @(posedge clk);
    ck("shutdown", shut, 0);
    rdck("status", OFS_STATUS, 0);
    rdck("count", 6'h1C, 0);
    $display("test shutdown done");
    // Enable low freezes timer and report; the last kind sent was system fatal
    bus(1'b1, OFS_CTRL, 32'(SCRUB_SHORTEST));
    ce <= 1'b0;
    e.valid <= 1'b1;
    @(posedge clk);
    ln = line;
    repeat (20) @(posedge clk);
    ck("frozen line", line, ln);
    ck("frozen mce", mce, 0);
    ce <= 1'b1;
    e.valid <= 1'b0;
    @(posedge clk);
    rdck("status", OFS_STATUS, 32'(ms));
    $display("test enable done");
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : test_error_scope_threshold_scrub
`default_nettype wire
